// File: hdl/cpu_bus_decode_glue.v
// Address decode, byte enables, start strobe and wait sequencer for the processor bus
`timescale 1ns/100ps
`include "cpu_bus_decode_map.vh"

module cpu_bus_decode_glue #(
	parameter IO_WAIT  = `IO_WAIT_CYCLES,
	parameter ROM_WAIT = `ROM_BYTE_CYCLES
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rstn,
	// Processor bus
	input  wire [31:0] addr,
	input  wire        readNotWrite,
	input  wire [1:0]  transferSize,
	input  wire [1:0]  transferType,
	input  wire        transferStart,
	input  wire [31:0] dataIn,
	output reg         transferAck,
	output reg  [31:0] dataOut,
	output reg         dataOeN,
	output reg         cacheBurstInhibit,
	output reg         iackSelect,
	// Memory controller
	input  wire        memCycleAck,
	output reg         memSelect,
	output reg         controllerStartStrobe,
	output reg         burstRequest,
	output reg  [3:0]  byteColumnStrobe,
	output reg         programLoadStrobe,
	// Peripheral selects
	output reg         romSelect,
	output reg         lightSelect,
	output reg         switchSelect,
	output reg         uartSelect,
	output reg         rtcSelect,
	output reg         slowRead,
	output reg         slowWrite,
	// Boot ROM
	input  wire [7:0]  romData,
	output wire [1:0]  romAddrLow,
	output wire        romRead,
	// Light and switch ports
	input  wire [3:0]  switchPins,
	input  wire [3:0]  presencePins,
	output reg  [7:0]  lightOut
);

	localparam ST_IDLE   = 3'h0;
	localparam ST_STEP1  = 3'h1;
	localparam ST_IOWAIT = 3'h2;
	localparam ST_ROM    = 3'h3;
	localparam ST_SINGLE = 3'h4;
	localparam ST_BURST  = 3'h5;
	localparam ST_END    = 3'h6;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function [3:0] laneEnables;
		input [1:0] low;
		input [1:0] size;
		begin
			case (size)
				2'h1: laneEnables = 4'h1 << low;
				2'h2: laneEnables = low[1] ? 4'hC : 4'h3;
				default: laneEnables = 4'hF;
			endcase
		end
	endfunction

	function [3:0] bigEndianLanes;
		input [3:0] lanes;
		begin
			bigEndianLanes = {lanes[0], lanes[1], lanes[2], lanes[3]};
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg  [7:0] pinMeta_reg;
	reg  [7:0] pinSync_reg;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pinMeta_reg <= 8'h00;
			pinSync_reg <= 8'h00;
		end else begin
			pinMeta_reg <= {switchPins, presencePins};
			pinSync_reg <= pinMeta_reg;
		end
	end

	// ----------------------------------------
	// First-stage decode
	// ----------------------------------------
	wire [2:0] topField;
	wire [3:0] lowField;
	wire       memHit;
	wire       otherHit;
	wire       iackHit;
	wire       romHit;
	wire       isBurst;

	assign topField = addr[`TOP_FIELD_HI:`TOP_FIELD_LO];
	assign lowField = addr[`LOW_FIELD_HI:`LOW_FIELD_LO];
	assign iackHit  = (transferType == `IACK_TYPE);
	assign memHit   = !iackHit && (topField == `TOP_MEMORY_SPACE);
	assign otherHit = !iackHit && (topField == `TOP_OTHER_SPACE);
	assign romHit   = otherHit && !addr[`PROGRAM_LOAD_BIT] && (lowField == `SEL_ROM);
	assign isBurst  = (transferSize == `LINE_SIZE);

	// ----------------------------------------
	// Latched cycle decode
	// ----------------------------------------
	reg        otherSel_reg;
	reg        write_reg;
	reg        burst_reg;
	reg  [3:0] field_reg;
	reg        loadRange_reg;
	reg        ackSeen_reg;
	reg  [2:0] beat_reg;
	reg        startPending_reg;
	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [3:0] wait_reg;
	reg        gatherStart;
	wire       gatherDone;
	wire [31:0] gatherWord;
	wire       stepOne;
	wire       seqAck;

	assign stepOne = (state_reg == ST_STEP1);
	assign seqAck  = ((state_reg == ST_IOWAIT) && (wait_reg == 4'h0))
		|| ((state_reg == ST_ROM) && gatherDone);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			otherSel_reg  <= 1'b0;
			write_reg     <= 1'b0;
			burst_reg     <= 1'b0;
			field_reg     <= 4'h0;
			loadRange_reg <= 1'b0;
		end else if (transferStart && (state_reg == ST_IDLE)) begin
			otherSel_reg  <= otherHit;
			write_reg     <= !readNotWrite;
			burst_reg     <= isBurst;
			field_reg     <= lowField;
			loadRange_reg <= addr[`PROGRAM_LOAD_BIT];
		end else if (transferAck) begin
			otherSel_reg  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Wait-state sequencer
	// ----------------------------------------
	always @* begin
		state_next  = state_reg;
		gatherStart = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (transferStart) begin
					if (memHit) begin
						state_next = isBurst ? ST_BURST : ST_SINGLE;
					end else if (romHit && readNotWrite) begin
						state_next  = ST_ROM;
						gatherStart = 1'b1;
					end else if (!iackHit) begin
						state_next = ST_STEP1;
					end
				end
			end
			ST_STEP1:  state_next = ST_IOWAIT;
			ST_IOWAIT: if (wait_reg == 4'h0) state_next = ST_END;
			ST_ROM:    if (gatherDone) state_next = ST_END;
			ST_SINGLE: if (memCycleAck) state_next = ST_END;
			ST_BURST:  if (memCycleAck && (beat_reg == `BURST_BEATS - 3'h1)) state_next = ST_END;
			ST_END:    state_next = ST_IDLE;
			default:   state_next = ST_IDLE;
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			wait_reg  <= 4'h0;
			beat_reg  <= 3'h0;
		end else begin
			state_reg <= state_next;
			if (stepOne) begin
				wait_reg <= IO_WAIT[3:0];
			end else if ((state_reg == ST_IOWAIT) && (wait_reg != 4'h0)) begin
				wait_reg <= wait_reg - 4'h1;
			end
			if (state_reg == ST_IDLE) begin
				beat_reg <= 3'h0;
			end else if ((state_reg == ST_BURST) && memCycleAck) begin
				beat_reg <= beat_reg + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Transfer acknowledge and data drive
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transferAck <= 1'b0;
			ackSeen_reg <= 1'b0;
			dataOut     <= 32'h0000_0000;
			dataOeN     <= 1'b1;
			lightOut    <= `LIGHT_RESET;
		end else begin
			transferAck <= seqAck
				|| (((state_reg == ST_SINGLE) || (state_reg == ST_BURST)) && memCycleAck);
			ackSeen_reg <= transferAck;
			dataOeN     <= 1'b1;
			if ((state_reg == ST_ROM) && gatherDone) begin
				dataOut <= gatherWord;
				dataOeN <= 1'b0;
			end else if (seqAck && otherSel_reg && !write_reg
				&& (field_reg == `SEL_SWITCH)) begin
				dataOut <= {pinSync_reg, 24'h00_0000};
				dataOeN <= 1'b0;
			end
			if (seqAck && otherSel_reg && write_reg && !loadRange_reg
				&& (field_reg == `SEL_LIGHT)) begin
				lightOut <= dataIn[`BYTE_LANE_HI:`BYTE_LANE_LO];
			end
		end
	end

	// ----------------------------------------
	// Memory controller side
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			memSelect             <= 1'b0;
			startPending_reg      <= 1'b0;
			controllerStartStrobe <= 1'b0;
			burstRequest          <= 1'b0;
			byteColumnStrobe      <= 4'h0;
			cacheBurstInhibit     <= 1'b0;
			iackSelect            <= 1'b0;
		end else begin
			startPending_reg      <= transferStart && memHit && (state_reg == ST_IDLE);
			controllerStartStrobe <= startPending_reg;
			if (transferStart && memHit && (state_reg == ST_IDLE)) begin
				memSelect        <= 1'b1;
				burstRequest     <= isBurst;
				byteColumnStrobe <= bigEndianLanes(laneEnables(addr[1:0], transferSize));
			end else begin
				if (burst_reg) begin
					if ((state_reg == ST_BURST) && memCycleAck
						&& (beat_reg == `BURST_BEATS - 3'h1)) begin
						memSelect <= 1'b0;
					end
					if ((state_reg == ST_BURST) && memCycleAck
						&& (beat_reg == `BURST_BEATS - 3'h2)) begin
						burstRequest <= 1'b0;
					end
				end else if (ackSeen_reg) begin
					memSelect <= 1'b0;
				end
				if (!memSelect) begin
					byteColumnStrobe <= 4'h0;
				end
			end
			if (transferStart && !memHit && (state_reg == ST_IDLE)) begin
				cacheBurstInhibit <= 1'b1;
			end else if (transferAck) begin
				cacheBurstInhibit <= 1'b0;
			end
			if (transferStart && iackHit) begin
				iackSelect <= 1'b1;
			end else if (transferAck) begin
				iackSelect <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Second-stage decode and slow strobes
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			romSelect         <= 1'b0;
			lightSelect       <= 1'b0;
			switchSelect      <= 1'b0;
			uartSelect        <= 1'b0;
			rtcSelect         <= 1'b0;
			programLoadStrobe <= 1'b0;
			slowRead          <= 1'b0;
			slowWrite         <= 1'b0;
		end else if (transferAck || seqAck) begin
			romSelect         <= 1'b0;
			lightSelect       <= 1'b0;
			switchSelect      <= 1'b0;
			uartSelect        <= 1'b0;
			rtcSelect         <= 1'b0;
			programLoadStrobe <= 1'b0;
			slowRead          <= 1'b0;
			slowWrite         <= 1'b0;
		end else if (stepOne && otherSel_reg) begin
			lightSelect  <= !loadRange_reg && (field_reg == `SEL_LIGHT) && write_reg;
			switchSelect <= !loadRange_reg && (field_reg == `SEL_SWITCH) && !write_reg;
			uartSelect   <= !loadRange_reg && (field_reg == `SEL_UART);
			rtcSelect    <= !loadRange_reg && (field_reg == `SEL_RTC);
			programLoadStrobe <= loadRange_reg && write_reg;
			slowRead     <= !write_reg;
			slowWrite    <= write_reg;
		end else if (gatherStart) begin
			romSelect <= 1'b1;
		end
	end

	// ----------------------------------------
	// Boot ROM byte gathering
	// ----------------------------------------
	rom_byte_gather #(
		.WAIT_CYCLES (ROM_WAIT)
	) gather (
		.clk        (clk),
		.rstn       (rstn),
		.start      (gatherStart),
		.done       (gatherDone),
		.word       (gatherWord),
		.romData    (romData),
		.romAddrLow (romAddrLow),
		.romRead    (romRead)
	);

endmodule

// File: hdl/cpu_bus_decode_map.vh
// Address map, field positions and timing counts for the bus decode glue
`ifndef CPU_BUS_DECODE_MAP_VH
`define CPU_BUS_DECODE_MAP_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS      40
`define IO_ACCESS_NS       120
`define IO_WAIT_CYCLES     ((`IO_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROM_BYTE_NS        160
`define ROM_BYTE_CYCLES    ((`ROM_BYTE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// First-stage decode on address bits 31..29
// ----------------------------------------
`define TOP_FIELD_HI       31
`define TOP_FIELD_LO       29
`define TOP_OTHER_SPACE    3'h0
`define TOP_MEMORY_SPACE   3'h1
`define IACK_TYPE          2'h3
`define LINE_SIZE          2'h3

// ----------------------------------------
// Second-stage decode on address bits 28..25
// ----------------------------------------
`define LOW_FIELD_HI       28
`define LOW_FIELD_LO       25
`define PROGRAM_LOAD_BIT   28
`define SEL_ROM            4'h0
`define SEL_LIGHT          4'h1
`define SEL_SWITCH         4'h2
`define SEL_UART           4'h3
`define SEL_RTC            4'h4

// ----------------------------------------
// Register offsets and data lanes
// ----------------------------------------
`define LIGHT_LATCH_ADDR   32'h0200_0000
`define SWITCH_INPUT_ADDR  32'h0400_0000
`define BYTE_LANE_HI       31
`define BYTE_LANE_LO       24
`define LIGHT_RESET        8'h00
`define BURST_BEATS        3'h4

`endif

// File: hdl/rom_byte_gather.v
// Boot ROM byte gathering machine: four byte reads form one word
`timescale 1ns/100ps
`include "cpu_bus_decode_map.vh"

module rom_byte_gather #(
	parameter WAIT_CYCLES = `ROM_BYTE_CYCLES
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rstn,
	// Control
	input  wire        start,
	output reg         done,
	output reg  [31:0] word,
	// ROM pins
	input  wire [7:0]  romData,
	output reg  [1:0]  romAddrLow,
	output reg         romRead
);

	reg [7:0] dataMeta_reg;
	reg [7:0] dataSync_reg;
	reg [3:0] wait_reg;
	reg       busy_reg;

	// ----------------------------------------
	// Byte stepping and holding registers
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dataMeta_reg <= 8'h00;
			dataSync_reg <= 8'h00;
			wait_reg     <= 4'h0;
			busy_reg     <= 1'b0;
			done         <= 1'b0;
			word         <= 32'h0000_0000;
			romAddrLow   <= 2'h0;
			romRead      <= 1'b0;
		end else begin
			dataMeta_reg <= romData;
			dataSync_reg <= dataMeta_reg;
			done         <= 1'b0;
			if (!busy_reg) begin
				if (start) begin
					busy_reg   <= 1'b1;
					romRead    <= 1'b1;
					romAddrLow <= 2'h0;
					wait_reg   <= WAIT_CYCLES[3:0] + 4'h2;
				end
			end else if (wait_reg != 4'h0) begin
				wait_reg <= wait_reg - 4'h1;
			end else begin
				case (romAddrLow)
					2'h0: word[31:24] <= dataSync_reg;
					2'h1: word[23:16] <= dataSync_reg;
					2'h2: word[15:8]  <= dataSync_reg;
					default: word[7:0] <= dataSync_reg;
				endcase
				if (romAddrLow == 2'h3) begin
					busy_reg   <= 1'b0;
					romRead    <= 1'b0;
					romAddrLow <= 2'h0;
					done       <= 1'b1;
				end else begin
					romAddrLow <= romAddrLow + 2'h1;
					wait_reg   <= WAIT_CYCLES[3:0] + 4'h2;
				end
			end
		end
	end

endmodule

// File: tb/bus_glue_chk.sv
// Port-level assertion checker for the bus decode glue
`timescale 1ns/100ps
module bus_glue_chk (
	// Clock and reset
	input wire        clk,
	input wire        rstn,
	// Processor side
	input wire [31:0] addr,
	input wire        readNotWrite,
	input wire [1:0]  transferSize,
	input wire [1:0]  transferType,
	input wire        transferStart,
	input wire        transferAck,
	input wire        cacheBurstInhibit,
	input wire        iackSelect,
	// Memory and peripheral side
	input wire        memCycleAck,
	input wire        memSelect,
	input wire        controllerStartStrobe,
	input wire        burstRequest,
	input wire        uartSelect,
	input wire        slowRead,
	input wire        slowWrite,
	input wire [1:0]  romAddrLow,
	input wire        romRead
);
	// ----------------------------------------
	// Beat counting
	// ----------------------------------------
	wire [2:0] topField = addr[31:29];
	reg  [2:0] beatCnt;
	reg        burstFlag;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			beatCnt   <= 3'h0;
			burstFlag <= 1'h0;
		end else if (transferStart) begin
			beatCnt   <= 3'h0;
			burstFlag <= transferSize == 2'h3;
		end else if (memCycleAck && memSelect)
			beatCnt <= beatCnt + 3'h1;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence memStart;
		transferStart && topField == 3'h1;
	endsequence
	sequence ioStart;
		transferStart && topField == 3'h0;
	endsequence
	a_start_strobe_delay: assert property (
		memStart |=> memSelect ##1 controllerStartStrobe)
		else $error("start strobe not one period after select");
	a_mem_select_cause: assert property (
		$rose(memSelect) |-> $past(transferStart) && $past(topField) == 3'h1)
		else $error("memory select rose without start");
	a_inhibit_other: assert property (ioStart |=> cacheBurstInhibit)
		else $error("burst inhibit missing");
	a_iack_select: assert property (
		transferStart && transferType == 2'h3 |=> iackSelect)
		else $error("iack select missing");
	a_io_select_late: assert property (
		ioStart and addr[28:25] == 4'h3 |=> !uartSelect ##1 uartSelect)
		else $error("io select not delayed one step");
	a_slow_read_late: assert property (
		ioStart and readNotWrite && addr[28:25] == 4'h2 |=> !slowRead ##1 slowRead)
		else $error("slow read not delayed");
	a_slow_write_late: assert property (
		ioStart and !readNotWrite |=> !slowWrite ##1 slowWrite)
		else $error("slow write not delayed");
	a_ack_from_ctrl: assert property (memSelect && memCycleAck |=> transferAck)
		else $error("controller ack not passed on");
	a_single_clear: assert property (
		memSelect && transferAck && !burstFlag |-> ##2 !memSelect)
		else $error("single select not cleared");
	a_burst_hold: assert property (
		burstFlag && memSelect && !(memCycleAck && beatCnt == 3'h3) |=> memSelect)
		else $error("burst select dropped early");
	a_burst_four: assert property (
		burstFlag && memCycleAck && beatCnt == 3'h3 |=> !memSelect)
		else $error("burst select kept after fourth ack");
	a_burst_req_drop: assert property (
		burstFlag && memCycleAck && beatCnt == 3'h2 |=> !burstRequest)
		else $error("burst request not removed");
	a_rom_step: assert property (
		romRead && $changed(romAddrLow) |-> romAddrLow == $past(romAddrLow) + 2'h1)
		else $error("rom address out of order");
	a_rom_start: assert property (
		transferStart && addr[31:25] == 7'h00 && readNotWrite
		|=> romRead && romAddrLow == 2'h0)
		else $error("rom gathering not started");
endmodule

// File: tb/far_side_model.sv
// Memory controller acknowledge and byte-wide boot ROM model
`timescale 1ns/100ps
module far_side_model (
	// Clock and pacing
	input  wire       clk,
	input  wire       slow,
	// Memory controller
	input  wire       controllerStartStrobe,
	input  wire       burstRequest,
	output reg        memCycleAck,
	// Boot ROM
	input  wire       romRead,
	input  wire [1:0] romAddrLow,
	output wire [7:0] romData
);
	reg [2:0] beats;
	reg [1:0] gap;
	initial begin
		memCycleAck = 1'h0;
		beats = 3'h0;
		gap = 2'h0;
	end
	assign romData = romRead ? {6'h28, romAddrLow} : ~{6'h28, romAddrLow};
	always @(posedge clk) begin
		memCycleAck <= 1'h0;
		if (controllerStartStrobe) begin
			beats <= burstRequest ? 3'h4 : 3'h1;
			gap   <= slow ? 2'h3 : 2'h1;
		end else if (beats != 3'h0) begin
			if (gap == 2'h0) begin
				memCycleAck <= 1'h1;
				beats       <= beats - 3'h1;
				gap         <= slow ? 2'h3 : 2'h1;
			end else
				gap <= gap - 2'h1;
		end
	end
endmodule

// File: tb/testbench.sv
// Self-checking testbench for the bus decode glue
`timescale 1ns/100ps
module testbench;
	reg         clk, rstn, readNotWrite, transferStart, slow, oeSeen;
	reg  [31:0] addr, dataIn, rdata;
	reg  [1:0]  transferSize, transferType;
	reg  [3:0]  switchPins, presencePins, lanes;
	reg  [7:0]  seen;
	reg  [46:0] rows [0:12];
	wire        transferAck, dataOeN, cacheBurstInhibit, iackSelect, memCycleAck, memSelect;
	wire        controllerStartStrobe, burstRequest, programLoadStrobe, romSelect, romRead;
	wire        lightSelect, switchSelect, uartSelect, rtcSelect, slowRead, slowWrite;
	wire [31:0] dataOut;
	wire [3:0]  byteColumnStrobe;
	wire [7:0]  romData, lightOut;
	wire [1:0]  romAddrLow;
	integer     badCount, checked, cycles, ackCnt, i;
	cpu_bus_decode_glue #(.IO_WAIT(3), .ROM_WAIT(1)) cpu_bus_decode_glue_inst (.clk, .rstn,
		.addr, .readNotWrite, .transferSize, .transferType, .transferStart, .dataIn,
		.transferAck, .dataOut, .dataOeN, .cacheBurstInhibit, .iackSelect, .memCycleAck,
		.memSelect, .controllerStartStrobe, .burstRequest, .byteColumnStrobe,
		.programLoadStrobe, .romSelect, .lightSelect, .switchSelect, .uartSelect,
		.rtcSelect, .slowRead, .slowWrite, .romData, .romAddrLow, .romRead, .switchPins,
		.presencePins, .lightOut);
	far_side_model far_side_model_inst (.clk, .slow, .controllerStartStrobe, .burstRequest,
		.memCycleAck, .romRead, .romAddrLow, .romData);
	// ----------------------------------------
	// Clock, monitor and timeout
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles = cycles + 1;
		seen = seen | {memSelect, romSelect, lightSelect, switchSelect, uartSelect,
			rtcSelect, programLoadStrobe, cacheBurstInhibit};
		if (memSelect)
			lanes = byteColumnStrobe;
		if (transferAck) begin
			ackCnt = ackCnt + 1;
			rdata = dataOut;
			oeSeen = !dataOeN;
		end
		if (cycles == 5000) begin
			badCount = badCount + 1;
			conclude;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				badCount = badCount + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task run(input [31:0] a, input rnw, input [1:0] sz, input [1:0] tt, input integer need);
		integer n;
		begin
			@(posedge clk);
			#1;
			seen = 8'h00;
			lanes = 4'h0;
			ackCnt = 0;
			oeSeen = 1'h0;
			addr = a;
			readNotWrite = rnw;
			transferSize = sz;
			transferType = tt;
			transferStart = 1'h1;
			@(posedge clk);
			#1;
			transferStart = 1'h0;
			n = 0;
			while (ackCnt < need && n < 300) begin
				@(posedge clk);
				n = n + 1;
			end
			repeat (4) @(posedge clk);
			#1;
			chk(ackCnt, need);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", checked, badCount);
			if (badCount == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{rstn, readNotWrite, transferStart, slow, oeSeen} = 5'h00;
		{addr, rdata, transferSize, transferType, seen, lanes} = 0;
		dataIn = 32'hA500_0000;
		switchPins = 4'h9;
		presencePins = 4'h6;
		{badCount, checked, cycles, ackCnt} = 0;
		rows[0] = {32'h2000_0000, 1'h1, 2'h1, 8'h80, 4'h8};
		rows[1] = {32'h2000_0001, 1'h1, 2'h1, 8'h80, 4'h4};
		rows[2] = {32'h2000_0002, 1'h0, 2'h1, 8'h80, 4'h2};
		rows[3] = {32'h2000_0003, 1'h0, 2'h1, 8'h80, 4'h1};
		rows[4] = {32'h2000_0002, 1'h1, 2'h2, 8'h80, 4'h3};
		rows[5] = {32'h3FFF_FFFC, 1'h0, 2'h0, 8'h80, 4'hF};
		rows[6] = {32'h0200_0000, 1'h0, 2'h1, 8'h21, 4'h0};
		rows[7] = {32'h0400_0000, 1'h1, 2'h1, 8'h11, 4'h0};
		rows[8] = {32'h0600_0000, 1'h1, 2'h1, 8'h09, 4'h0};
		rows[9] = {32'h0800_0000, 1'h0, 2'h1, 8'h05, 4'h0};
		rows[10] = {32'h1000_0000, 1'h0, 2'h0, 8'h03, 4'h0};
		rows[11] = {32'h1FFF_FFFC, 1'h1, 2'h0, 8'h01, 4'h0};
		rows[12] = {32'h0000_0000, 1'h1, 2'h0, 8'h41, 4'h0};
		repeat (16) @(posedge clk);
		#1;
		rstn = 1'h1;
		chk({dataOeN, lightOut, romAddrLow, memSelect}, {1'h1, 8'h00, 2'h0, 1'h0});
		$display("test reset done");
		for (i = 0; i < 13; i = i + 1) begin
			run(rows[i][46:15], rows[i][14], rows[i][13:12], 2'h0, 1);
			chk(seen, rows[i][11:4]);
			chk(lanes, rows[i][3:0]);
		end
		chk(lightOut, 8'hA5);
		chk({rdata, oeSeen}, {32'hA0A1_A2A3, 1'h1});
		$display("test table done");
		run(32'h0400_0000, 1'h1, 2'h1, 2'h0, 1);
		chk({rdata[31:24], oeSeen}, {8'h96, 1'h1});
		$display("test switch done");
		for (i = 0; i < 2; i = i + 1) begin
			slow = i;
			run(32'h2000_0010, i, 2'h3, 2'h0, 4);
			chk(seen[7], 1'h1);
		end
		$display("test burst done");
		run(32'hFFFF_FFF0, 1'h1, 2'h0, 2'h3, 0);
		chk(iackSelect, 1'h1);
		$display("test iack done");
		rstn = 1'h0;
		@(posedge clk);
		#1;
		chk({iackSelect, cacheBurstInhibit, dataOeN}, 3'h1);
		chk(lightOut, 8'h00);
		rstn = 1'h1;
		run(32'h2000_0000, 1'h1, 2'h1, 2'h0, 1);
		chk(lanes, 4'h8);
		$display("test mid reset done");
		conclude;
	end
endmodule
bind cpu_bus_decode_glue bus_glue_chk bus_glue_chk_inst (.clk, .rstn, .addr, .readNotWrite,
	.transferSize, .transferType, .transferStart, .transferAck, .cacheBurstInhibit,
	.iackSelect, .memCycleAck, .memSelect, .controllerStartStrobe, .burstRequest,
	.uartSelect, .slowRead, .slowWrite, .romAddrLow, .romRead);
